// File: test/lsr_i2c_host.sv
`timescale 1ns/1ps
// Bit-banged bus host; SCL idles high and stands still between frames
module lsr_i2c_host (
  // Wire level and host drive
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_low_o
);
  // Quarter step keeps SDA moves clear of SCL edges after the target's sync
  localparam int HQ = 90;
  localparam int HH = 180;

  initial
  begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end

  task automatic clk_bit(input logic low, output logic seen);
    #HQ sda_low_o = low;
    #HQ scl_o = 1'b1;
    #HH seen = sda_i;
    scl_o = 1'b0;
  endtask

  task automatic start_cond();
    if (scl_o === 1'b0)
    begin
      #HQ sda_low_o = 1'b0;
      #HQ scl_o = 1'b1;
      #HH;
    end
    sda_low_o = 1'b1;
    #HH scl_o = 1'b0;
  endtask

  task automatic stop_cond();
    #HQ sda_low_o = 1'b1;
    #HQ scl_o = 1'b1;
    #HH sda_low_o = 1'b0;
    #HH;
  endtask

  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      clk_bit(~b[i], s);
    clk_bit(1'b0, s);
    ack = (s === 1'b0);
  endtask

  task automatic recv_byte(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      clk_bit(1'b0, s);
      b[i] = s;
    end
    clk_bit(~last, s);
  endtask

  // Command, repeated start, low byte acked, high byte refused
  task automatic read_reg(input logic [7:0] cmd, output logic [15:0] w);
    logic a;
    start_cond();
    send_byte(8'h20, a);
    send_byte(cmd, a);
    start_cond();
    send_byte(8'h21, a);
    recv_byte(1'b0, w[7:0]);
    recv_byte(1'b1, w[15:8]);
    stop_cond();
  endtask

  task automatic write_reg(input logic [7:0] cmd, input logic [15:0] w);
    logic a;
    start_cond();
    send_byte(8'h20, a);
    send_byte(cmd, a);
    send_byte(w[7:0], a);
    send_byte(w[15:8], a);
    stop_cond();
  endtask
endmodule

// File: test/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  typedef struct {
    logic [15:0] ps;
    int per;
    logic [15:0] amb;
    logic [15:0] brd;
    logic [15:0] st;
  } lsr_row_t;

  logic clk_sys_i;
  logic rst_n_i;
  logic link_clk_i;
  logic scl;
  logic host_low;
  logic sda_wire;
  logic sda_o;
  logic sda_oe_o;
  logic meas_done_i;
  logic [15:0] amb_count_i;
  logic [15:0] broad_count_i;
  logic meas_start_o;
  lsr_row_t rows [5];
  int fails;
  int samples_checked;
  int cyc;
  int starts;
  int t0;
  int t1;
  logic [15:0] v;

  lsr_regs_top #(.CYC_PER_MS(1)) dut (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .link_clk_i(link_clk_i),
    .scl_i(scl),
    .sda_i(sda_wire),
    .sda_o(sda_o),
    .sda_oe_o(sda_oe_o),
    .meas_done_i(meas_done_i),
    .amb_count_i(amb_count_i),
    .broad_count_i(broad_count_i),
    .meas_start_o(meas_start_o)
  );

  lsr_i2c_host host (
    .sda_i(sda_wire),
    .scl_o(scl),
    .sda_low_o(host_low)
  );

  // Open-drain wire with pull-up
  assign sda_wire = ((sda_oe_o === 1'b1) ? sda_o : 1'b1) & ~host_low;

  always #4 clk_sys_i = ~clk_sys_i;

  initial
  begin
    link_clk_i = 1'b0;
    #7.3;
    forever #15 link_clk_i = ~link_clk_i;
  end

  always @(posedge clk_sys_i)
    cyc <= cyc + 1;

  // Converter answers every start after a fixed conversion time
  always @(negedge clk_sys_i)
    if (meas_start_o === 1'b1)
    begin
      fork
        begin
          repeat (20) @(negedge clk_sys_i);
          meas_done_i = 1'b1;
          @(negedge clk_sys_i);
          meas_done_i = 1'b0;
        end
      join_none
    end

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic wait_start(output int at);
    int n;
    for (n = 0; n < 5000; n++)
    begin
      @(negedge clk_sys_i);
      if (meas_start_o === 1'b1)
        break;
    end
    at = cyc;
    if (n == 5000)
    begin
      fails++;
      $display("conversion start never came");
      end_sim();
    end
  endtask

  task automatic rd(input logic [7:0] cmd, input logic [15:0] exp, input string name);
    logic [15:0] w;
    host.read_reg(cmd, w);
    check(name, w, exp);
  endtask

  task automatic set_counts(input logic [15:0] a, input logic [15:0] b);
    @(negedge clk_sys_i);
    amb_count_i = a;
    broad_count_i = b;
  endtask

  initial
  begin
    clk_sys_i = 1'b0;
    rst_n_i = 1'b0;
    meas_done_i = 1'b0;
    amb_count_i = 16'h0000;
    broad_count_i = 16'h0000;
    cyc = 0;
    fails = 0;
    samples_checked = 0;
    starts = 0;
    rows[0] = '{16'h0006, 100, 16'h9ABC, 16'h1357, 16'h0000};
    rows[1] = '{16'h0001, 600, 16'h1000, 16'hC3F0, 16'h0000};
    rows[2] = '{16'h0003, 1100, 16'hF00D, 16'h00FF, 16'h4000};
    rows[3] = '{16'hFFFD, 2100, 16'h0034, 16'hFF00, 16'h8000};
    rows[4] = '{16'h0007, 4100, 16'h01FF, 16'h8001, 16'h8000};
    // Long enough for the link side reset too
    repeat (16) @(negedge clk_sys_i);
    rst_n_i = 1'b1;
    repeat (400)
    begin
      @(negedge clk_sys_i);
      if (meas_start_o === 1'b1)
        starts++;
    end
    check("starts in shutdown", starts[15:0], 16'h0000);
    rd(8'h06, 16'h0000, "status after reset");
    $display("test reset done");
    host.write_reg(8'h01, 16'h1000);
    host.write_reg(8'h02, 16'h0200);
    foreach (rows[i])
    begin
      set_counts(rows[i].amb, rows[i].brd);
      if (i < 2)
        host.write_reg(8'h00, (i == 0) ? 16'h0000 : 16'h0002);
      host.write_reg(8'h03, rows[i].ps);
      wait_start(t0);
      repeat (25) @(negedge clk_sys_i);
      // Clears flags left by the previous counts
      host.read_reg(8'h06, v);
      wait_start(t0);
      wait_start(t1);
      check("refresh in range", {15'h0000, (t1 - t0 >= rows[i].per) && (t1 - t0 <= rows[i].per + 2)}, 16'h0001);
      repeat (25) @(negedge clk_sys_i);
      rd(8'h04, rows[i].amb, "ambient result");
      rd(8'h05, rows[i].brd, "broadband result");
      rd(8'h06, rows[i].st, "status");
      $display("test row %0d done", i);
    end
    host.write_reg(8'h00, 16'h0003);
    repeat (300) @(negedge clk_sys_i);
    host.read_reg(8'h06, v);
    set_counts(16'h0003, 16'h4242);
    rd(8'h04, 16'h01FF, "ambient kept in shutdown");
    host.write_reg(8'h00, 16'h0002);
    wait_start(t0);
    repeat (25) @(negedge clk_sys_i);
    host.write_reg(8'h00, 16'h0003);
    rd(8'h04, 16'h0003, "ambient after wake");
    host.write_reg(8'h06, 16'h0000);
    rd(8'h06, 16'h8000, "status after write");
    rd(8'h06, 16'h0000, "status after read");
    $display("test shutdown and flags done");
    end_sim();
  end
endmodule

// File: verilog/lsr_defs.svh
`ifndef LSR_DEFS_SVH
`define LSR_DEFS_SVH

// Command codes
`define LSR_CMD_CONF 8'h00
`define LSR_CMD_THR_HIGH 8'h01
`define LSR_CMD_THR_LOW 8'h02
`define LSR_CMD_POWER_SAVE 8'h03
`define LSR_CMD_AMBIENT 8'h04
`define LSR_CMD_BROADBAND 8'h05
`define LSR_CMD_STATUS 8'h06

// Bus address, 7 bits
`define LSR_I2C_ADDR 7'h10

// Configuration fields
`define LSR_CONF_SHUTDOWN_BIT 0
`define LSR_CONF_IRQ_EN_BIT 1
`define LSR_CONF_IT_MSB 9
`define LSR_CONF_IT_LSB 6
`define LSR_CONF_RST 16'h0001

// Power-saving fields
`define LSR_PS_ENABLE_BIT 0
`define LSR_PS_SEL_MSB 2
`define LSR_PS_SEL_LSB 1
`define LSR_PS_SEL_RST 2'h0

// Status fields
`define LSR_ST_BELOW_BIT 15
`define LSR_ST_ABOVE_BIT 14

// Integration period codes
`define LSR_IT_25MS 4'hC
`define LSR_IT_50MS 4'h8
`define LSR_IT_100MS 4'h0
`define LSR_IT_200MS 4'h1
`define LSR_IT_400MS 4'h2
`define LSR_IT_800MS 4'h3

// Timing
`define LSR_CLK_PERIOD_NS 8
`define LSR_NS_PER_MS 1000000
`define LSR_CYC_PER_MS (`LSR_NS_PER_MS / `LSR_CLK_PERIOD_NS)
`define LSR_PSM_BASE_MS 500

`endif

// File: verilog/lsr_i2c_link.sv
`timescale 1ns/1ps
`include "lsr_defs.svh"
// Oversampling serial target on the link clock; words leave under toggles.
module lsr_i2c_link (
  // Link clock and reset
  input wire logic link_clk_i,
  input wire logic rst_n_i,
  // Serial pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  // Towards register domain
  input wire logic [15:0] rd_data_i,
  output logic wr_tgl_o,
  output logic cap_tgl_o,
  output logic rd_tgl_o,
  output logic [7:0] cmd_o,
  output logic [15:0] wr_data_o
);

  logic rst_m_q;
  logic lrst_n_q;
  logic scl_m_q;
  logic scl_s_q;
  logic scl_p_q;
  logic sda_m_q;
  logic sda_s_q;
  logic sda_p_q;
  lsr_pkg::lsr_link_st_t st_q;
  logic [3:0] bit_cnt_q;
  logic [7:0] sr_q;
  logic [7:0] tx_q;
  logic [7:0] lsb_q;
  logic byte_q;
  logic nack_q;
  logic rise;
  logic fall;
  logic start;
  logic stop;

  always_ff @(posedge link_clk_i)
  begin
    rst_m_q <= rst_n_i;
    lrst_n_q <= rst_m_q;
  end

  always_ff @(posedge link_clk_i)
  begin
    if (!lrst_n_q)
    begin
      scl_m_q <= 1'b1;
      scl_s_q <= 1'b1;
      scl_p_q <= 1'b1;
      sda_m_q <= 1'b1;
      sda_s_q <= 1'b1;
      sda_p_q <= 1'b1;
      sda_o <= 1'b0;
    end
    else
    begin
      scl_m_q <= scl_i;
      scl_s_q <= scl_m_q;
      scl_p_q <= scl_s_q;
      sda_m_q <= sda_i;
      sda_s_q <= sda_m_q;
      sda_p_q <= sda_s_q;
      sda_o <= 1'b0;
    end
  end

  assign rise = scl_s_q & ~scl_p_q;
  assign fall = ~scl_s_q & scl_p_q;
  assign start = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
  assign stop = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;

  // Byte order on the wire: low byte first, then high byte
  always_ff @(posedge link_clk_i)
  begin
    if (!lrst_n_q)
    begin
      st_q <= lsr_pkg::LK_IDLE;
      bit_cnt_q <= 4'h0;
      sr_q <= 8'h00;
      tx_q <= 8'h00;
      lsb_q <= 8'h00;
      byte_q <= 1'b0;
      nack_q <= 1'b0;
      sda_oe_o <= 1'b0;
      wr_tgl_o <= 1'b0;
      cap_tgl_o <= 1'b0;
      rd_tgl_o <= 1'b0;
      cmd_o <= 8'h00;
      wr_data_o <= 16'h0000;
    end
    else if (start)
    begin
      st_q <= lsr_pkg::LK_ADDR;
      bit_cnt_q <= 4'hF; // The START's own SCL fall wraps this to 0, not a data bit
      sda_oe_o <= 1'b0;
    end
    else if (stop)
    begin
      st_q <= lsr_pkg::LK_IDLE;
      sda_oe_o <= 1'b0;
    end
    else if (st_q != lsr_pkg::LK_IDLE)
    begin
      if (rise)
      begin
        if (bit_cnt_q < 4'h8)
          sr_q <= {sr_q[6:0], sda_s_q};
        else
          nack_q <= sda_s_q;
      end
      if (fall)
      begin
        if (bit_cnt_q == 4'h7)
        begin
          bit_cnt_q <= 4'h8;
          if (st_q == lsr_pkg::LK_RDATA)
            sda_oe_o <= 1'b0;
          else if (st_q == lsr_pkg::LK_ADDR)
            sda_oe_o <= (sr_q[7:1] == `LSR_I2C_ADDR);
          else
            sda_oe_o <= 1'b1;
        end
        else if (bit_cnt_q == 4'h8)
        begin
          bit_cnt_q <= 4'h0;
          sda_oe_o <= 1'b0;
          case (st_q)
            lsr_pkg::LK_ADDR:
            begin
              if (sr_q[7:1] != `LSR_I2C_ADDR)
                st_q <= lsr_pkg::LK_IDLE;
              else if (sr_q[0])
              begin
                st_q <= lsr_pkg::LK_RDATA;
                byte_q <= 1'b0;
                tx_q <= rd_data_i[7:0];
                sda_oe_o <= ~rd_data_i[7];
              end
              else
                st_q <= lsr_pkg::LK_CMD;
            end
            lsr_pkg::LK_CMD:
            begin
              cmd_o <= sr_q;
              cap_tgl_o <= ~cap_tgl_o;
              st_q <= lsr_pkg::LK_WDATA;
              byte_q <= 1'b0;
            end
            lsr_pkg::LK_WDATA:
            begin
              if (!byte_q)
              begin
                lsb_q <= sr_q;
                byte_q <= 1'b1;
              end
              else
              begin
                wr_data_o <= {sr_q, lsb_q};
                wr_tgl_o <= ~wr_tgl_o;
                st_q <= lsr_pkg::LK_IDLE;
              end
            end
            lsr_pkg::LK_RDATA:
            begin
              if (nack_q)
              begin
                rd_tgl_o <= ~rd_tgl_o;
                st_q <= lsr_pkg::LK_IDLE;
              end
              else
              begin
                byte_q <= ~byte_q;
                tx_q <= byte_q ? rd_data_i[7:0] : rd_data_i[15:8];
                sda_oe_o <= byte_q ? ~rd_data_i[7] : ~rd_data_i[15];
              end
            end
            default:
              st_q <= lsr_pkg::LK_IDLE;
          endcase
        end
        else
        begin
          bit_cnt_q <= bit_cnt_q + 4'h1;
          if (st_q == lsr_pkg::LK_RDATA)
          begin
            tx_q <= {tx_q[6:0], 1'b0};
            sda_oe_o <= ~tx_q[6];
          end
        end
      end
    end
  end

endmodule

// File: verilog/lsr_pkg.sv
package lsr_pkg;

  typedef enum logic [2:0] {
    LK_IDLE,
    LK_ADDR,
    LK_CMD,
    LK_WDATA,
    LK_RDATA
  } lsr_link_st_t;

  typedef enum logic [1:0] {
    MS_OFF,
    MS_CONV,
    MS_WAIT
  } lsr_meas_st_t;

endpackage

// File: verilog/lsr_regs_top.sv
`timescale 1ns/1ps
`include "lsr_defs.svh"
// Operation
// - Power-save bits 2:1 select mode 1 to 4 (00 to 11).
// - Power-save bit 0 enables the selected low-power refresh mode.
// - Power-save bits 15:3 are reserved and ignored by the device.
// - Ambient result is a 16-bit read-only register at code 04h.
// - Ambient result: high byte in bits 15:8, low byte in 7:0.
// - Broadband result is a 16-bit read-only register at code 05h.
// - Broadband result: high byte in bits 15:8, low byte in 7:0.
// - Status bit 15 sets when ambient falls below low threshold.
// - Status bit 14 sets when ambient rises above high threshold.
// - Below-window flag is read-only; status writes leave it unchanged.
// - Above-window flag is read-only; status bits 13:0 are reserved.
// - With power save, refresh period is integration plus 500ms times 2^(mode-1).
// - Configuration bit 0 shuts measurement down; shutdown after reset.
// - Last results are kept through shutdown; fresh measurement overwrites them.
// - Flags only with window enable set and both thresholds programmed.
module lsr_regs_top #(
  parameter int CYC_PER_MS = `LSR_CYC_PER_MS
) (
  // System clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Serial link
  input wire logic link_clk_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  // Converter front end
  input wire logic meas_done_i,
  input wire logic [15:0] amb_count_i,
  input wire logic [15:0] broad_count_i,
  output logic meas_start_o
);

  logic wr_tgl;
  logic cap_tgl;
  logic rd_tgl;
  logic [7:0] link_cmd;
  logic [15:0] link_wr_data;
  logic wr_p;
  logic cap_p;
  logic rd_p;
  logic [15:0] conf_q;
  logic [15:0] thr_high_q;
  logic [15:0] thr_low_q;
  logic thr_high_set_q;
  logic thr_low_set_q;
  logic [1:0] power_save_select_q;
  logic power_save_enable_q;
  logic [15:0] amb_q;
  logic [15:0] broad_q;
  logic below_window_flag_q;
  logic above_window_flag_q;
  logic [15:0] hold_q;
  lsr_pkg::lsr_meas_st_t mst_q;
  logic [16:0] tick_cnt_q;
  logic [12:0] elapsed_q;
  logic tick;
  logic shutdown_bit;
  logic window_irq_enable;
  logic [12:0] period_ms;
  logic done_ok;
  logic flags_armed;
  logic set_below;
  logic set_above;

  function automatic logic [12:0] it_ms(input logic [3:0] code);
    case (code)
      `LSR_IT_25MS: it_ms = 13'd25;
      `LSR_IT_50MS: it_ms = 13'd50;
      `LSR_IT_200MS: it_ms = 13'd200;
      `LSR_IT_400MS: it_ms = 13'd400;
      `LSR_IT_800MS: it_ms = 13'd800;
      default: it_ms = 13'd100;
    endcase
  endfunction

  function automatic logic [12:0] refresh_ms(input logic [3:0] code, input logic en,
                                             input logic [1:0] sel);
    logic [12:0] base;
    base = 13'(`LSR_PSM_BASE_MS);
    refresh_ms = it_ms(code) + (en ? (base << sel) : 13'h0000);
  endfunction

  lsr_i2c_link u_link (
    .link_clk_i(link_clk_i),
    .rst_n_i(rst_n_i),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .sda_o(sda_o),
    .sda_oe_o(sda_oe_o),
    .rd_data_i(hold_q),
    .wr_tgl_o(wr_tgl),
    .cap_tgl_o(cap_tgl),
    .rd_tgl_o(rd_tgl),
    .cmd_o(link_cmd),
    .wr_data_o(link_wr_data)
  );

  // Command and write data stay frozen in the link until the next transfer
  lsr_tog_sync u_wr_sync (
    .clk_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .tgl_i(wr_tgl),
    .pulse_o(wr_p)
  );

  lsr_tog_sync u_cap_sync (
    .clk_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .tgl_i(cap_tgl),
    .pulse_o(cap_p)
  );

  lsr_tog_sync u_rd_sync (
    .clk_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .tgl_i(rd_tgl),
    .pulse_o(rd_p)
  );

  assign shutdown_bit = conf_q[`LSR_CONF_SHUTDOWN_BIT];
  assign window_irq_enable = conf_q[`LSR_CONF_IRQ_EN_BIT];
  assign period_ms = refresh_ms(conf_q[`LSR_CONF_IT_MSB:`LSR_CONF_IT_LSB],
                                power_save_enable_q, power_save_select_q);
  assign tick = (tick_cnt_q == 17'(CYC_PER_MS - 1));
  assign done_ok = meas_done_i && (mst_q == lsr_pkg::MS_CONV);
  assign flags_armed = window_irq_enable && thr_high_set_q && thr_low_set_q;
  assign set_below = done_ok && flags_armed && (amb_count_i < thr_low_q);
  assign set_above = done_ok && flags_armed && (amb_count_i > thr_high_q);

  // Writable registers
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      conf_q <= `LSR_CONF_RST;
      thr_high_q <= 16'h0000;
      thr_low_q <= 16'h0000;
      thr_high_set_q <= 1'b0;
      thr_low_set_q <= 1'b0;
      power_save_select_q <= `LSR_PS_SEL_RST;
      power_save_enable_q <= 1'b0;
    end
    else if (wr_p)
    begin
      case (link_cmd)
        `LSR_CMD_CONF: conf_q <= link_wr_data;
        `LSR_CMD_THR_HIGH:
        begin
          thr_high_q <= link_wr_data;
          thr_high_set_q <= 1'b1;
        end
        `LSR_CMD_THR_LOW:
        begin
          thr_low_q <= link_wr_data;
          thr_low_set_q <= 1'b1;
        end
        `LSR_CMD_POWER_SAVE:
        begin
          // Bits 15:3 dropped on purpose
          power_save_select_q <= link_wr_data[`LSR_PS_SEL_MSB:`LSR_PS_SEL_LSB];
          power_save_enable_q <= link_wr_data[`LSR_PS_ENABLE_BIT];
        end
        default: ;
      endcase
    end
  end

  // Millisecond base and refresh sequencing
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
      tick_cnt_q <= 17'h00000;
    else if (tick)
      tick_cnt_q <= 17'h00000;
    else
      tick_cnt_q <= tick_cnt_q + 17'h00001;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      mst_q <= lsr_pkg::MS_OFF;
      elapsed_q <= 13'h0000;
      meas_start_o <= 1'b0;
    end
    else
    begin
      meas_start_o <= 1'b0;
      if (tick && elapsed_q != 13'h1FFF)
        elapsed_q <= elapsed_q + 13'h0001;
      case (mst_q)
        lsr_pkg::MS_OFF:
        begin
          if (!shutdown_bit)
          begin
            meas_start_o <= 1'b1;
            elapsed_q <= 13'h0000;
            mst_q <= lsr_pkg::MS_CONV;
          end
        end
        lsr_pkg::MS_CONV:
        begin
          if (meas_done_i)
            mst_q <= shutdown_bit ? lsr_pkg::MS_OFF : lsr_pkg::MS_WAIT;
        end
        lsr_pkg::MS_WAIT:
        begin
          if (shutdown_bit)
            mst_q <= lsr_pkg::MS_OFF;
          else if (elapsed_q >= period_ms)
          begin
            meas_start_o <= 1'b1;
            elapsed_q <= 13'h0000;
            mst_q <= lsr_pkg::MS_CONV;
          end
        end
        default: mst_q <= lsr_pkg::MS_OFF;
      endcase
    end
  end

  // Results change only on a finished conversion, so shutdown keeps them
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      amb_q <= 16'h0000;
      broad_q <= 16'h0000;
    end
    else if (done_ok)
    begin
      amb_q <= amb_count_i;
      broad_q <= broad_count_i;
    end
  end

  // Set wins over the read-completion clear; host writes never reach here
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      below_window_flag_q <= 1'b0;
      above_window_flag_q <= 1'b0;
    end
    else
    begin
      if (set_below)
        below_window_flag_q <= 1'b1;
      else if (rd_p && link_cmd == `LSR_CMD_STATUS)
        below_window_flag_q <= 1'b0;
      if (set_above)
        above_window_flag_q <= 1'b1;
      else if (rd_p && link_cmd == `LSR_CMD_STATUS)
        above_window_flag_q <= 1'b0;
    end
  end

  // Whole word captured once, so both bytes come from one measurement
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
      hold_q <= 16'h0000;
    else if (cap_p)
    begin
      case (link_cmd)
        `LSR_CMD_AMBIENT: hold_q <= amb_q;
        `LSR_CMD_BROADBAND: hold_q <= broad_q;
        `LSR_CMD_STATUS: hold_q <= {below_window_flag_q, above_window_flag_q, 14'h0000};
        default: hold_q <= 16'h0000;
      endcase
    end
  end

  property p_ps_write;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    wr_p && link_cmd == `LSR_CMD_POWER_SAVE |=>
      {power_save_select_q, power_save_enable_q} == $past(link_wr_data[2:0]);
  endproperty
  a_ps_write: assert property (p_ps_write) else $error("power-save field not decoded");

  property p_ps_off_period;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    !power_save_enable_q |-> period_ms == it_ms(conf_q[`LSR_CONF_IT_MSB:`LSR_CONF_IT_LSB]);
  endproperty
  a_ps_off_period: assert property (p_ps_off_period) else $error("period not gated");

  property p_refresh_hold;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    mst_q == lsr_pkg::MS_WAIT && elapsed_q < period_ms |=> !meas_start_o;
  endproperty
  a_refresh_hold: assert property (p_refresh_hold) else $error("refresh came early");

  property p_shutdown_quiet;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    shutdown_bit && mst_q != lsr_pkg::MS_OFF ##1 shutdown_bit |-> !meas_start_o;
  endproperty
  a_shutdown_quiet: assert property (p_shutdown_quiet) else $error("start in shutdown");

  property p_result_latch;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    done_ok |=> amb_q == $past(amb_count_i) && broad_q == $past(broad_count_i);
  endproperty
  a_result_latch: assert property (p_result_latch) else $error("result not latched");

  property p_result_kept;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    mst_q == lsr_pkg::MS_OFF |=> $stable(amb_q) && $stable(broad_q);
  endproperty
  a_result_kept: assert property (p_result_kept) else $error("result lost in shutdown");

  property p_below_set;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    done_ok && window_irq_enable && thr_low_set_q && thr_high_set_q
      && amb_count_i < thr_low_q |=> below_window_flag_q;
  endproperty
  a_below_set: assert property (p_below_set) else $error("below flag missed");

  property p_above_set;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    done_ok && flags_armed && amb_count_i > thr_high_q |=> above_window_flag_q;
  endproperty
  a_above_set: assert property (p_above_set) else $error("above flag missed");

  property p_flags_need_enable;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    !flags_armed && !below_window_flag_q |=> !below_window_flag_q;
  endproperty
  a_flags_need_enable: assert property (p_flags_need_enable) else $error("flag unarmed");

  property p_status_write;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    wr_p && !done_ok && !rd_p |=> $stable(below_window_flag_q) && $stable(above_window_flag_q);
  endproperty
  a_status_write: assert property (p_status_write) else $error("flag changed by write");

  property p_status_clear;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    rd_p && link_cmd == `LSR_CMD_STATUS && !set_below && !set_above |=>
      !below_window_flag_q && !above_window_flag_q;
  endproperty
  a_status_clear: assert property (p_status_clear) else $error("flags not cleared");

  property p_capture;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    cap_p && link_cmd == `LSR_CMD_AMBIENT |=> hold_q == $past(amb_q);
  endproperty
  a_capture: assert property (p_capture) else $error("capture wrong");

  c_ps_write: cover property (@(posedge clk_sys_i) wr_p && link_cmd == `LSR_CMD_POWER_SAVE);
  c_flag_set: cover property (@(posedge clk_sys_i) set_below || set_above);
  c_status_rd: cover property (@(posedge clk_sys_i) rd_p && link_cmd == `LSR_CMD_STATUS);
  c_refresh: cover property (@(posedge clk_sys_i) meas_start_o && power_save_enable_q);

endmodule

// File: verilog/lsr_tog_sync.sv
`timescale 1ns/1ps
// Carries one event per toggle into the destination clock.
module lsr_tog_sync (
  // Destination clock
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Event
  input wire logic tgl_i,
  output logic pulse_o
);

  logic meta_q;
  logic sync_q;
  logic prev_q;

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
      pulse_o <= 1'b0;
    end
    else
    begin
      meta_q <= tgl_i;
      sync_q <= meta_q;
      prev_q <= sync_q;
      pulse_o <= sync_q ^ prev_q;
    end
  end

endmodule
